// >>> t8oc_pkg.sv
// Package with register map, field layout, reset values and carrier types of the compare unit.
package t8oc_pkg;

    localparam logic [7:0] T8OC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] T8OC_ADDR_CLKSEL = 8'h04;
    localparam logic [7:0] T8OC_ADDR_COUNT  = 8'h08;
    localparam logic [7:0] T8OC_ADDR_CMPA   = 8'h0C;
    localparam logic [7:0] T8OC_ADDR_CMPB   = 8'h10;
    localparam logic [7:0] T8OC_ADDR_FLAGS  = 8'h14;
    localparam logic [7:0] T8OC_ADDR_MASK   = 8'h18;
    localparam logic [7:0] T8OC_ADDR_FORCE  = 8'h1C;
    localparam logic [7:0] T8OC_ADDR_STATE  = 8'h20;

    localparam int T8OC_FLAG_OVF = 0;
    localparam int T8OC_FLAG_A   = 1;
    localparam int T8OC_NCHAN    = 2;

    localparam logic [2:0] T8OC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] T8OC_MODE_CTC    = 3'h2;
    localparam logic [2:0] T8OC_CLK_STOP    = 3'h0;
    localparam logic [7:0] T8OC_MAX         = 8'hFF;
    localparam logic [7:0] T8OC_BOTTOM      = 8'h00;
    localparam logic [7:0] T8OC_CNT_RESET   = 8'h00;
    localparam logic [7:0] T8OC_CMP_RESET   = 8'h00;

    localparam logic [1:0] T8OC_ACT_NONE   = 2'h0;
    localparam logic [1:0] T8OC_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] T8OC_ACT_CLEAR  = 2'h2;
    localparam logic [1:0] T8OC_ACT_SET    = 2'h3;

    localparam logic [1:0] T8OC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] T8OC_RESP_SLVERR = 2'h2;

    // Control word: bits [6:5] action B, [4:3] action A, [2:0] waveform mode.
    typedef struct packed {
        logic [1:0] output_action_sel_b;
        logic [1:0] output_action_sel_a;
        logic [2:0] waveform_mode_sel;
    } t8oc_ctrl_t;

    localparam t8oc_ctrl_t T8OC_CTRL_RESET = 7'h00;

    // Flag word: bit 0 overflow, bit 1 match A, bit 2 match B.
    typedef struct packed {
        logic [T8OC_NCHAN-1:0] match_flag_chan;
        logic                  overflow_flag;
    } t8oc_flags_t;

    localparam t8oc_flags_t T8OC_FLAGS_RESET = 3'h0;

endpackage : t8oc_pkg

// >>> t8oc_top.sv
// Output compare and waveform unit of an 8-bit timer, with an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps

module t8oc_top
    import t8oc_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  timer_tick,
    input  wire logic [2:0]            irq_ack,
    input  wire logic [T8OC_NCHAN-1:0] port_latch,
    input  wire logic [T8OC_NCHAN-1:0] pin_dir,
    output logic [T8OC_NCHAN-1:0]      pin_out,
    output logic [T8OC_NCHAN-1:0]      pin_oe,
    output logic [2:0]                 irq_req,
    output logic                       at_top,
    output logic                       at_bottom
);

    t8oc_ctrl_t            ctrl;
    t8oc_flags_t           flags;
    logic [2:0]            irq_mask;
    logic [2:0]            clock_source_sel;
    logic [7:0]            counter_value;
    logic                  count_down;
    logic                  match_block;
    logic [7:0]            cmp_active [T8OC_NCHAN];
    logic [7:0]            cmp_buffer [T8OC_NCHAN];
    logic [T8OC_NCHAN-1:0] compare_output_state;
    logic [1:0]            act        [T8OC_NCHAN];

    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_full;
    logic        w_full;
    logic        wr_do;
    logic        wr_lane0;
    logic        ar_take;
    logic        aw_take;
    logic        w_take;

    logic        pwm;
    logic        dual_slope;
    logic        tclk;
    logic [7:0]  top_value;
    logic        reach_top;
    logic        ctc_clear;
    logic [7:0]  next_counter;
    logic        next_down;
    logic        ovf_event;
    logic [T8OC_NCHAN-1:0] match;
    logic [T8OC_NCHAN-1:0] force_hit;

    // Channel index 0 is A and index 1 is B everywhere in this block.
    assign act[0] = ctrl.output_action_sel_a;
    assign act[1] = ctrl.output_action_sel_b;

    // Odd mode codes are the pulse-width modes; modes 1 and 5 count up and down.
    assign pwm        = ctrl.waveform_mode_sel[0];
    assign dual_slope = pwm && !ctrl.waveform_mode_sel[1];
    assign tclk       = timer_tick && (clock_source_sel != T8OC_CLK_STOP);
    // Clear-on-match and the pulse-width modes with code bit 2 take their top from channel A.
    assign top_value  = ((pwm && ctrl.waveform_mode_sel[2]) ||
                         (ctrl.waveform_mode_sel == T8OC_MODE_CTC)) ? cmp_active[0]
                                                                    : T8OC_MAX;
    assign reach_top  = tclk && !count_down && (counter_value == top_value);

    // AXI4-Lite write channel: address and data are latched in either order.
    // A pending response stalls the next write, so a slow bready only costs bus time.
    assign aw_take  = s_axi_awvalid && s_axi_awready;
    assign w_take   = s_axi_wvalid && s_axi_wready;
    assign wr_do    = aw_full && w_full && !s_axi_bvalid;
    assign wr_lane0 = wr_do && w_strb[0];
    assign ar_take  = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (aw_take) begin
            aw_full       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_do) begin
            aw_full       <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (w_take) begin
            w_full       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_do) begin
            w_full       <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Writes above the last register are ignored but still answered, with an error code.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= T8OC_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[7:2] > T8OC_ADDR_STATE[7:2]) ? T8OC_RESP_SLVERR
                                                                  : T8OC_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: one read in flight; data is sampled on the address handshake.
    // Address bits [1:0] are ignored, so an unaligned read returns the word it falls in.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= T8OC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= T8OC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                T8OC_ADDR_CTRL:   s_axi_rdata <= {25'h0, ctrl};
                T8OC_ADDR_CLKSEL: s_axi_rdata <= {29'h0, clock_source_sel};
                T8OC_ADDR_COUNT:  s_axi_rdata <= {24'h0, counter_value};
                T8OC_ADDR_CMPA:   s_axi_rdata <= {24'h0, pwm ? cmp_buffer[0] : cmp_active[0]};
                T8OC_ADDR_CMPB:   s_axi_rdata <= {24'h0, pwm ? cmp_buffer[1] : cmp_active[1]};
                T8OC_ADDR_FLAGS:  s_axi_rdata <= {29'h0, flags};
                T8OC_ADDR_MASK:   s_axi_rdata <= {29'h0, irq_mask};
                T8OC_ADDR_FORCE:  s_axi_rdata <= 32'h0000_0000;
                T8OC_ADDR_STATE:  s_axi_rdata <= {30'h0, compare_output_state};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= T8OC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Configuration registers.
    // Action fields are not buffered, so a new action is seen by the very next match.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl             <= T8OC_CTRL_RESET;
            clock_source_sel <= T8OC_CLK_STOP;
            irq_mask         <= 3'h0;
        end else if (wr_lane0) begin
            if (aw_addr == T8OC_ADDR_CTRL)
                ctrl <= w_data[6:0];
            if (aw_addr == T8OC_ADDR_CLKSEL)
                clock_source_sel <= w_data[2:0];
            if (aw_addr == T8OC_ADDR_MASK)
                irq_mask <= w_data[2:0];
        end
    end

    // Counter sequencing depends on the waveform mode and the channel A compare value, never on the actions.
    // The dual-slope branch turns at top and reports overflow on reaching bottom.
    always_comb begin
        ctc_clear    = (ctrl.waveform_mode_sel == T8OC_MODE_CTC) && match[0];
        next_counter = counter_value + 8'h01;
        next_down    = count_down;
        ovf_event    = 1'b0;
        if (dual_slope) begin
            if (!count_down && counter_value == top_value) begin
                next_counter = counter_value - 8'h01;
                next_down    = 1'b1;
            end else if (count_down) begin
                next_counter = counter_value - 8'h01;
                ovf_event    = (counter_value == 8'h01);
                next_down    = (counter_value != 8'h01);
            end
        end else if (pwm) begin
            if (counter_value == top_value) begin
                next_counter = T8OC_BOTTOM;
                ovf_event    = 1'b1;
            end
        end else if (ctc_clear) begin
            // A top of FF clears straight from the maximum, which is still a roll to zero.
            next_counter = T8OC_BOTTOM;
            ovf_event    = (counter_value == T8OC_MAX);
        end else begin
            ovf_event = (counter_value == T8OC_MAX);
        end
    end

    // A bus write takes priority over a tick in the same cycle; later ticks count on from the written value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_value <= T8OC_CNT_RESET;
            count_down    <= 1'b0;
        end else if (wr_lane0 && aw_addr == T8OC_ADDR_COUNT) begin
            counter_value <= w_data[7:0];
        end else if (tclk) begin
            counter_value <= next_counter;
            count_down    <= next_down && dual_slope;
        end
    end

    // The block holds until the next timer tick, so a stopped timer keeps it armed.
    // Software that loads equal compare and count values relies on it to avoid a false flag.
    always_ff @(posedge aclk) begin
        if (!aresetn)
            match_block <= 1'b0;
        else if (wr_lane0 && aw_addr == T8OC_ADDR_COUNT)
            match_block <= 1'b1;
        else if (tclk)
            match_block <= 1'b0;
    end

    // A set and a clear in the same cycle leave the flag set, so no event is lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags.overflow_flag <= 1'b0;
        end else if (tclk && ovf_event) begin
            flags.overflow_flag <= 1'b1;
        end else if (irq_ack[T8OC_FLAG_OVF] ||
                     (wr_lane0 && aw_addr == T8OC_ADDR_FLAGS && w_data[T8OC_FLAG_OVF])) begin
            flags.overflow_flag <= 1'b0;
        end
    end

    // Both channels share one body; besides the address that loads the compare value, only channel A toggles in PWM, and only in modes 5 and 7.
    genvar ch;
    generate
        for (ch = 0; ch < T8OC_NCHAN; ch++) begin : g_chan
            logic [7:0] cmp_addr;
            logic       cmp_write;
            assign cmp_addr  = (ch == 0) ? T8OC_ADDR_CMPA : T8OC_ADDR_CMPB;
            assign cmp_write = wr_lane0 && aw_addr == cmp_addr;
            assign match[ch] = tclk && !match_block &&
                               counter_value == cmp_active[ch];
            assign force_hit[ch] = wr_lane0 && aw_addr == T8OC_ADDR_FORCE &&
                                   w_data[ch] && !pwm;

            // Outside the pulse-width modes a write lands in both copies, so a switch starts clean.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cmp_buffer[ch] <= T8OC_CMP_RESET;
                    cmp_active[ch] <= T8OC_CMP_RESET;
                end else begin
                    if (cmp_write)
                        cmp_buffer[ch] <= w_data[7:0];
                    if (cmp_write && !pwm)
                        cmp_active[ch] <= w_data[7:0];
                    else if (pwm && reach_top)
                        cmp_active[ch] <= cmp_buffer[ch];
                end
            end

            // The match takes priority over a clear that arrives in the same cycle.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flags.match_flag_chan[ch] <= 1'b0;
                end else if (match[ch]) begin
                    flags.match_flag_chan[ch] <= 1'b1;
                end else if (irq_ack[T8OC_FLAG_A+ch] ||
                             (wr_lane0 && aw_addr == T8OC_ADDR_FLAGS &&
                              w_data[T8OC_FLAG_A+ch])) begin
                    flags.match_flag_chan[ch] <= 1'b0;
                end
            end

            // PWM modes use action bit 0 as polarity; the wrap edge restores the idle level unless a match falls on the same tick.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    compare_output_state[ch] <= 1'b0;
                end else if (act[ch] == T8OC_ACT_NONE) begin
                    compare_output_state[ch] <= compare_output_state[ch];
                end else if (!pwm && (match[ch] || force_hit[ch])) begin
                    case (act[ch])
                        T8OC_ACT_TOGGLE: compare_output_state[ch] <= !compare_output_state[ch];
                        T8OC_ACT_CLEAR:  compare_output_state[ch] <= 1'b0;
                        T8OC_ACT_SET:    compare_output_state[ch] <= 1'b1;
                        default:         compare_output_state[ch] <= compare_output_state[ch];
                    endcase
                end else if (pwm && act[ch] == T8OC_ACT_TOGGLE) begin
                    if (ch == 0 && ctrl.waveform_mode_sel[2] && match[ch])
                        compare_output_state[ch] <= !compare_output_state[ch];
                end else if (pwm && match[ch]) begin
                    compare_output_state[ch] <= count_down ? !act[ch][0] : act[ch][0];
                end else if (pwm && !dual_slope && reach_top) begin
                    compare_output_state[ch] <= !act[ch][0];
                end
            end

            // The pin path adds one cycle of latency; the override follows the action field only.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_out[ch] <= 1'b0;
                    pin_oe[ch]  <= 1'b0;
                end else begin
                    pin_out[ch] <= (act[ch] != T8OC_ACT_NONE) ? compare_output_state[ch]
                                                              : port_latch[ch];
                    pin_oe[ch]  <= pin_dir[ch];
                end
            end
        end
    endgenerate

    // Requests and the top and bottom strobes lag their sources by one cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req   <= 3'h0;
            at_top    <= 1'b0;
            at_bottom <= 1'b0;
        end else begin
            irq_req   <= flags & irq_mask;
            at_top    <= (counter_value == top_value);
            at_bottom <= (counter_value == T8OC_BOTTOM);
        end
    end

endmodule : t8oc_top

// >>> t8oc_properties.sv
// Port checker for the compare unit, bound to its top module.
`timescale 1ns/1ps

module t8oc_properties
    import t8oc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        timer_tick,
    input wire logic [2:0]  irq_ack,
    input wire logic [1:0]  pin_dir,
    input wire logic [1:0]  pin_oe,
    input wire logic [2:0]  irq_req,
    input wire logic        at_bottom
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_oe; $past(aresetn) |-> pin_oe == $past(pin_dir); endproperty
    a_oe: assert property (p_oe) else $error("pin enable does not follow direction");
    property p_ack_ovf; irq_ack[0] && !timer_tick |=> ##1 !irq_req[0]; endproperty
    a_ack_ovf: assert property (p_ack_ovf) else $error("overflow request not cleared");
    property p_ack_a; irq_ack[1] && !timer_tick |=> ##1 !irq_req[1]; endproperty
    a_ack_a: assert property (p_ack_a) else $error("match request not cleared");
    // Without a tick or a write in flight the counter must not move, as seen on the bottom strobe.
    property p_hold;
        !timer_tick && s_axi_awready && !s_axi_awvalid |=> ##1 $stable(at_bottom);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved without a tick");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_rstand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rstand: assert property (p_rstand) else $error("read data dropped");
    property p_slverr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > T8OC_ADDR_STATE[7:2]
            |=> s_axi_rresp == T8OC_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
endmodule : t8oc_properties

bind t8oc_top t8oc_properties u_chk (.*);

// >>> t8oc_cpu_model.sv
// AXI4-Lite master standing in for the processor core.
`timescale 1ns/1ps

module t8oc_cpu_model (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // Each channel is released only at the edge where it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : t8oc_cpu_model

// >>> tb_top.sv
// Self-checking bench for the compare unit.
`timescale 1ns/1ps

module tb_top;
    import t8oc_pkg::*;
    logic        aclk, aresetn, timer_tick, at_top, at_bottom;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, r;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, port_latch, pin_dir, pin_out, pin_oe;
    logic [2:0]  irq_ack, irq_req;
    logic [33:0] expq[$];
    int          mismatches, check_count;
    logic [31:0] acts[5] = '{32'h18, 32'h10, 32'h08, 32'h08, 32'h00};
    logic [31:0] sts[5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0};

    t8oc_top uut (.*);
    t8oc_cpu_model m (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic stop_test;
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic rdx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rr = 2'h0);
        expq.push_back({rr, d});
        m.rd(a);
    endtask : rdx

    task automatic tk(input int n);
        repeat (n) begin
            @(posedge aclk) timer_tick <= 1'b1;
            @(posedge aclk) timer_tick <= 1'b0;
        end
    endtask : tk

    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            chk("read", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            chk("bresp", 34'(s_axi_bresp), (s_axi_awaddr > T8OC_ADDR_STATE) ?
                34'(T8OC_RESP_SLVERR) : 34'(T8OC_RESP_OKAY));
    end

    initial begin
        #100us;
        mismatches++;
        stop_test();
    end

    initial begin
        {timer_tick, irq_ack, port_latch, pin_dir, aresetn} = '0;
        r = 8'($urandom(55984));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdx(T8OC_ADDR_STATE, 32'h0);
        rdx(T8OC_ADDR_CTRL, 32'h0);
        rdx(8'h24, 32'h0, T8OC_RESP_SLVERR);
        m.wr(8'h24, 32'h1);
        for (int i = 0; i < 5; i++) begin
            m.wr(T8OC_ADDR_CTRL, acts[i]);
            m.wr(T8OC_ADDR_FORCE, 32'h1);
            rdx(T8OC_ADDR_STATE, sts[i]);
        end
        rdx(T8OC_ADDR_FLAGS, 32'h0);
        // Output state is settled before the pins are turned to outputs.
        pin_dir <= 2'h3;
        port_latch <= 2'($urandom());
        repeat (3) @(posedge aclk);
        chk("pin", 34'(pin_out), 34'(port_latch));
        chk("oe", 34'(pin_oe), 34'h3);
        m.wr(T8OC_ADDR_CTRL, 32'h08);
        m.wr(T8OC_ADDR_FORCE, 32'h1);
        m.wr(T8OC_ADDR_CTRL, 32'h0B);
        rdx(T8OC_ADDR_STATE, 32'h1);
        chk("pin_pwm", 34'(pin_out), 34'({port_latch[1], 1'b1}));
        m.wr(T8OC_ADDR_CTRL, 32'h08);
        m.wr(T8OC_ADDR_CMPA, 32'h5);
        m.wr(T8OC_ADDR_COUNT, 32'h5);
        m.wr(T8OC_ADDR_CLKSEL, 32'h1);
        tk(1);
        rdx(T8OC_ADDR_FLAGS, 32'h0);
        rdx(T8OC_ADDR_COUNT, 32'h6);
        m.wr(T8OC_ADDR_MASK, 32'h3);
        m.wr(T8OC_ADDR_COUNT, 32'h4);
        tk(2);
        rdx(T8OC_ADDR_FLAGS, 32'h2);
        rdx(T8OC_ADDR_STATE, 32'h0);
        chk("irq", 34'(irq_req), 34'h2);
        m.wr(T8OC_ADDR_FLAGS, 32'h2);
        rdx(T8OC_ADDR_FLAGS, 32'h0);
        m.wr(T8OC_ADDR_COUNT, 32'hFF);
        tk(1);
        rdx(T8OC_ADDR_FLAGS, 32'h1);
        rdx(T8OC_ADDR_COUNT, 32'h0);
        chk("irq_ovf", 34'(irq_req), 34'h1);
        @(posedge aclk) irq_ack <= 3'h7;
        @(posedge aclk) irq_ack <= 3'h0;
        rdx(T8OC_ADDR_FLAGS, 32'h0);
        m.wr(T8OC_ADDR_CMPA, 32'h2);
        m.wr(T8OC_ADDR_CTRL, 32'h0A);
        m.wr(T8OC_ADDR_COUNT, 32'h0);
        for (int i = 1; i >= 0; i--) begin
            tk(3);
            rdx(T8OC_ADDR_COUNT, 32'h0);
            rdx(T8OC_ADDR_STATE, 32'(i));
        end
        rdx(T8OC_ADDR_FLAGS, 32'h6);
        m.wr(T8OC_ADDR_FLAGS, 32'h7);
        m.wr(T8OC_ADDR_COUNT, 32'h5);
        tk(251);
        rdx(T8OC_ADDR_COUNT, 32'h0);
        rdx(T8OC_ADDR_FLAGS, 32'h1);
        chk("bottom", 34'(at_bottom), 34'h1);
        chk("top", 34'(at_top), 34'h0);
        m.wr(T8OC_ADDR_CMPB, 32'h30);
        m.wr(T8OC_ADDR_CTRL, 32'h03);
        m.wr(T8OC_ADDR_CMPB, 32'h12);
        m.wr(T8OC_ADDR_COUNT, 32'h11);
        m.wr(T8OC_ADDR_FLAGS, 32'h7);
        tk(2);
        rdx(T8OC_ADDR_FLAGS, 32'h0);
        m.wr(T8OC_ADDR_COUNT, 32'hFE);
        tk(2);
        m.wr(T8OC_ADDR_COUNT, 32'h11);
        m.wr(T8OC_ADDR_FLAGS, 32'h7);
        tk(2);
        rdx(T8OC_ADDR_FLAGS, 32'h4);
        // Ticks run through the whole write: the written value wins, one tick follows.
        @(posedge aclk) timer_tick <= 1'b1;
        m.wr(T8OC_ADDR_COUNT, 32'h40);
        timer_tick <= 1'b0;
        rdx(T8OC_ADDR_COUNT, 32'h41);
        m.wr(T8OC_ADDR_CLKSEL, 32'h0);
        m.wr(T8OC_ADDR_COUNT, 32'(r));
        tk(2);
        rdx(T8OC_ADDR_COUNT, 32'(r));
        m.wr(T8OC_ADDR_CTRL, 32'h02);
        m.wr(T8OC_ADDR_COUNT, 32'h2);
        repeat (2) @(posedge aclk);
        chk("top", 34'(at_top), 34'h1);
        chk("bottom", 34'(at_bottom), 34'h0);
        repeat (4) @(posedge aclk);
        stop_test();
    end
endmodule : tb_top
